/* File: adc_conversion_serial_readout.sv */
// Convert, sleep and data output sequencer with the 3-wire serial port
`timescale 1ns/1ps
`default_nettype none

module adc_conversion_serial_readout #(
    parameter int unsigned EXT_WINDOW_CYC = adc_pkg::EXT_WINDOW_CYC
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    input  wire logic                  rejection_select_pin,
    input  wire logic                  cs_n,
    input  wire logic                  sck_in,
    input  wire logic signed [29:0]    conv_value,
    output adc_pkg::serial_pins_s      pins,
    output logic                       conv_busy,
    output logic                       ext_clk_active,
    output logic                       osc_on
);

    adc_pkg::conv_state_e state_q;
    adc_pkg::conv_state_e state_d;
    adc_pkg::cnt_t        cnt_q;
    adc_pkg::bit_t        fall_q;
    adc_pkg::ph_t         ph_q;
    logic [31:0]          sh_q;
    logic                 cs_q;
    logic                 sck_q;
    logic                 init_q;
    logic                 int_mode_q;
    logic                 int_sck_q;
    logic                 sdo_q;
    logic                 sdo_oe_q;
    logic                 sck_oe_q;
    logic                 osc_on_q;
    logic                 conv_tick;
    logic                 cs_fall;
    logic                 cs_rise;
    logic                 int_run;
    logic                 tog;
    logic                 s_rise;
    logic                 s_fall;
    logic                 conv_done;

    // Out-of-range codes clamp; zero reads with the sign flag set
    function automatic adc_pkg::word_s format_word(
        input logic signed [29:0] v
    );
        adc_pkg::word_s    w;
        logic signed [29:0] c;
        c = v;
        if (v > adc_pkg::CLAMP_HI) begin
            c = adc_pkg::CLAMP_HI;
        end
        if (v < adc_pkg::CLAMP_LO) begin
            c = adc_pkg::CLAMP_LO;
        end
        w.pending             = 1'b0;
        w.filler_bit          = 1'b0;
        w.polarity_flag       = ~c[29];
        w.range_exceeded_flag = c[29] | c[28];
        {w.result, w.sub_bits} = c[27:0];
        return w;
    endfunction

    conv_clock_source #(
        .EXT_WINDOW_CYC (EXT_WINDOW_CYC)
    ) u_clk_src (
        .ref_clk              (ref_clk),
        .rst                  (rst),
        .rejection_select_pin (rejection_select_pin),
        .conv_tick            (conv_tick),
        .ext_active           (ext_clk_active)
    );

    assign cs_fall = cs_q & ~cs_n;
    assign cs_rise = ~cs_q & cs_n;

    assign int_run = int_mode_q & ~cs_n & (state_q != adc_pkg::ST_CONV);
    assign tog     = int_run & conv_tick & (ph_q == adc_pkg::SCK_HALF_LAST);

    // clocks ignored when high
    // Edges count only once select was low at the last sample as well,
    // so a mode change at the select fall cannot fake a first edge
    assign s_rise = ~cs_n & ~cs_q & (int_mode_q ? (tog & ~int_sck_q)
                                                : (sck_in & ~sck_q));
    assign s_fall = ~cs_n & ~cs_q & (int_mode_q ? (tog & int_sck_q)
                                                : (~sck_in & sck_q));

    assign conv_done = conv_tick & (cnt_q == adc_pkg::CONV_LAST);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cs_q  <= 1'b1;
            sck_q <= 1'b1;
        end else begin
            cs_q  <= cs_n;
            sck_q <= sck_in;
        end
    end

    // mode capture points
    // The first clocked cycle after reset stands in for power-up
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            init_q     <= 1'b0;
            int_mode_q <= 1'b1;
        end else if (!init_q || cs_fall) begin
            init_q     <= 1'b1;
            int_mode_q <= sck_in;
        end
    end

    // Internal clock idles low so its first toggle is a rising edge
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ph_q      <= '0;
            int_sck_q <= 1'b0;
        end else if (!int_run) begin
            ph_q      <= '0;
            int_sck_q <= 1'b0;
        end else if (conv_tick) begin
            ph_q <= ph_q + 1'b1;
            if (tog) begin
                int_sck_q <= ~int_sck_q;
            end
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            adc_pkg::ST_CONV: begin
                if (conv_done) begin
                    state_d = adc_pkg::ST_SLEEP;
                end
            end
            adc_pkg::ST_SLEEP: begin
                if (s_rise) begin
                    state_d = adc_pkg::ST_DOUT;
                end
            end
            adc_pkg::ST_DOUT: begin
                if (cs_rise || (s_fall && fall_q == adc_pkg::LAST_FALL)) begin
                    state_d = adc_pkg::ST_CONV;
                end
            end
            default: begin
                state_d = adc_pkg::ST_CONV;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= adc_pkg::ST_CONV;
            cnt_q   <= '0;
            fall_q  <= '0;
        end else begin
            state_q <= state_d;
            if (state_q != adc_pkg::ST_CONV) begin
                cnt_q <= '0;
            end else if (conv_tick) begin
                cnt_q <= cnt_q + 1'b1;
            end
            if (state_q != adc_pkg::ST_DOUT) begin
                fall_q <= '0;
            end else if (s_fall) begin
                fall_q <= fall_q + 1'b1;
            end
        end
    end

    // Result is frozen at the end of conversion so output is static
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sh_q <= '0;
        end else if (state_q == adc_pkg::ST_CONV && conv_done) begin
            sh_q <= format_word(conv_value);
        end else if (state_q == adc_pkg::ST_DOUT && s_fall) begin
            sh_q <= {sh_q[adc_pkg::WORD_W-2:0], 1'b0};
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sdo_q <= 1'b1;
        end else if (state_d == adc_pkg::ST_CONV) begin
            sdo_q <= 1'b1;
        end else if (state_d == adc_pkg::ST_SLEEP) begin
            sdo_q <= 1'b0;
        end else if (s_fall) begin
            sdo_q <= sh_q[adc_pkg::SHIFT_OUT_BIT];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sdo_oe_q  <= 1'b0;
            sck_oe_q  <= 1'b0;
            conv_busy <= 1'b1;
            osc_on_q  <= 1'b1;
        end else begin
            sdo_oe_q  <= ~cs_n;
            sck_oe_q  <= int_mode_q & ~cs_n;
            conv_busy <= (state_d == adc_pkg::ST_CONV);
            osc_on_q  <= ~ext_clk_active;
        end
    end

    assign pins.sdo     = sdo_q;
    assign pins.sdo_oe  = sdo_oe_q;
    assign pins.sck_out = int_sck_q;
    assign pins.sck_oe  = sck_oe_q;
    assign osc_on       = osc_on_q;

    a_pending_high : assert property (
        @(posedge ref_clk) disable iff (rst)
        (state_q == adc_pkg::ST_CONV && $past(state_q) == adc_pkg::ST_CONV)
            |-> sdo_q
    ) else $error("pending flag low during conversion");

    a_release_sdo : assert property (
        @(posedge ref_clk) disable iff (rst)
        cs_n |=> !pins.sdo_oe
    ) else $error("data pin driven with select high");

    a_last_fall : assert property (
        @(posedge ref_clk) disable iff (rst)
        (state_q == adc_pkg::ST_DOUT && s_fall
            && fall_q == adc_pkg::LAST_FALL)
            |=> (state_q == adc_pkg::ST_CONV && sdo_q && cnt_q == '0)
    ) else $error("no new conversion after last fall");

    a_abort_rise : assert property (
        @(posedge ref_clk) disable iff (rst)
        (state_q == adc_pkg::ST_DOUT && cs_rise)
            |=> state_q == adc_pkg::ST_CONV
    ) else $error("select rise did not abort output");

    a_sleep_hold : assert property (
        @(posedge ref_clk) disable iff (rst)
        (state_q == adc_pkg::ST_SLEEP && !s_rise)
            |=> state_q == adc_pkg::ST_SLEEP
    ) else $error("sleep left without clock rise");

    a_conv_length : assert property (
        @(posedge ref_clk) disable iff (rst)
        (state_q == adc_pkg::ST_SLEEP
            && $past(state_q) == adc_pkg::ST_CONV)
            |-> $past(cnt_q) == adc_pkg::CONV_LAST && $past(conv_tick)
    ) else $error("conversion ended at wrong count");

    a_word_lead : assert property (
        @(posedge ref_clk) disable iff (rst)
        (state_q == adc_pkg::ST_SLEEP) |-> sh_q[31:30] == 2'h0 && !sdo_q
    ) else $error("leading word bits not zero");

    a_clamp_high : assert property (
        @(posedge ref_clk) disable iff (rst)
        (state_q == adc_pkg::ST_CONV && conv_done
            && conv_value > adc_pkg::CLAMP_HI)
            |=> sh_q == adc_pkg::WORD_CLAMP_HI
    ) else $error("high clamp word wrong");

    a_clamp_low : assert property (
        @(posedge ref_clk) disable iff (rst)
        (state_q == adc_pkg::ST_CONV && conv_done
            && conv_value < adc_pkg::CLAMP_LO)
            |=> sh_q == adc_pkg::WORD_CLAMP_LO
    ) else $error("low clamp word wrong");

    a_ext_no_drive : assert property (
        @(posedge ref_clk) disable iff (rst)
        (!int_mode_q && !$past(int_mode_q)) |-> !pins.sck_oe
    ) else $error("clock pin driven in external mode");

endmodule

`default_nettype wire

/* File: adc_pkg.sv */
// Shared constants, types and field layout of the converter sequencer
package adc_pkg;

    // Reference clock
    localparam int unsigned CLK_PERIOD_NS = 4;

    // Conversion timing: length in conversion clock periods, durations in ms, minimum external rate in Hz
    localparam int unsigned CONV_PERIODS  = 20480;
    localparam int unsigned CONV_60_MS    = 133;
    localparam int unsigned CONV_50_MS    = 160;
    localparam int unsigned EXT_MIN_HZ    = 2560;
    localparam int unsigned NS_PER_MS     = 1000000;
    localparam int unsigned NS_PER_S      = 1000000000;

    // Internal oscillator period in reference cycles (rounded down)
    localparam int unsigned OSC60_CYC =
        CONV_60_MS * NS_PER_MS / (CLK_PERIOD_NS * CONV_PERIODS);
    localparam int unsigned OSC50_CYC =
        CONV_50_MS * NS_PER_MS / (CLK_PERIOD_NS * CONV_PERIODS);
    // Longest gap between external clock edges that still counts as present
    localparam int unsigned EXT_WINDOW_CYC =
        NS_PER_S / (EXT_MIN_HZ * CLK_PERIOD_NS);

    // Serial clock divider and word length
    localparam int unsigned SCK_DIV  = 8;
    localparam int unsigned WORD_W   = 32;

    typedef logic [10:0] div_t;
    typedef logic [16:0] gap_t;
    typedef logic [14:0] cnt_t;
    typedef logic [4:0]  bit_t;
    typedef logic [1:0]  ph_t;

    localparam div_t OSC60_LAST    = div_t'(OSC60_CYC - 1);
    localparam div_t OSC50_LAST    = div_t'(OSC50_CYC - 1);
    localparam cnt_t CONV_LAST     = cnt_t'(CONV_PERIODS - 1);
    localparam bit_t LAST_FALL     = bit_t'(WORD_W - 1);
    localparam ph_t  SCK_HALF_LAST = ph_t'(SCK_DIV / 2 - 1);
    localparam int unsigned SHIFT_OUT_BIT = WORD_W - 2;

    // Input code in sub-step units; full reference is 2**28
    localparam logic signed [29:0] CLAMP_HI = 30'sh11ff_ffff;
    localparam logic signed [29:0] CLAMP_LO = 30'sh3e00_0000;
    localparam logic [31:0] WORD_CLAMP_HI   = 32'h31ff_ffff;
    localparam logic [31:0] WORD_CLAMP_LO   = 32'h1e00_0000;

    typedef enum logic [2:0] {
        ST_CONV  = 3'h1,
        ST_SLEEP = 3'h2,
        ST_DOUT  = 3'h4
    } conv_state_e;

    typedef struct packed {
        logic        pending;
        logic        filler_bit;
        logic        polarity_flag;
        logic        range_exceeded_flag;
        logic [23:0] result;
        logic [3:0]  sub_bits;
    } word_s;

    typedef struct packed {
        logic sdo;
        logic sdo_oe;
        logic sck_out;
        logic sck_oe;
    } serial_pins_s;

endpackage

/* File: conv_clock_source.sv */
// Conversion clock source: internal oscillator or detected external clock
`timescale 1ns/1ps
`default_nettype none

module conv_clock_source #(
    parameter int unsigned EXT_WINDOW_CYC = adc_pkg::EXT_WINDOW_CYC
) (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic rejection_select_pin,
    output logic      conv_tick,
    output logic      ext_active
);

    localparam adc_pkg::gap_t WIN = adc_pkg::gap_t'(EXT_WINDOW_CYC);

    logic          pin_q;
    adc_pkg::gap_t gap_q;
    adc_pkg::div_t div_q;
    adc_pkg::div_t div_last;
    logic          pin_rise;
    logic          osc_tick;

    assign pin_rise = rejection_select_pin & ~pin_q;

    assign div_last = rejection_select_pin ? adc_pkg::OSC50_LAST
                                           : adc_pkg::OSC60_LAST;
    // Compare with >= so a rate change mid-period cannot run past the end
    assign osc_tick = (div_q >= div_last);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= rejection_select_pin;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        // Start as if silent, so a single edge after reset is not a clock
        if (rst) begin
            gap_q      <= WIN;
            ext_active <= 1'b0;
        end else if (pin_rise) begin
            ext_active <= (gap_q < WIN);
            gap_q      <= '0;
        end else if (gap_q >= WIN) begin
            ext_active <= 1'b0;
        end else begin
            gap_q <= gap_q + 1'b1;
        end
    end

    // Oscillator is held stopped while the external clock runs
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            div_q <= '0;
        end else if (ext_active || osc_tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            conv_tick <= 1'b0;
        end else begin
            conv_tick <= ext_active ? pin_rise : osc_tick;
        end
    end

    a_ext_detect : assert property (
        @(posedge ref_clk) disable iff (rst)
        (pin_rise && gap_q < WIN) |=> ext_active
    ) else $error("external clock not detected");

    a_int_return : assert property (
        @(posedge ref_clk) disable iff (rst)
        (!pin_rise && gap_q >= WIN) |=> !ext_active
    ) else $error("internal oscillator not restored");

endmodule

`default_nettype wire

/* File: spi_host_model.sv */
// Host side of the 3-wire port: chip select, serial clock and word capture
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
    input  wire logic ref_clk,
    input  wire logic sdo,
    input  wire logic sck_line,
    output logic      cs_n,
    output logic      sck_drv,
    output logic      sck_en
);
    initial begin
        cs_n    = 1'b1;
        sck_drv = 1'b0;
        sck_en  = 1'b1;
    end

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // clock level at select fall
    // Driving the pin low picks host clocking; letting go leaves the pull-up
    task automatic select(input logic ext);
        sck_en  = ext;
        sck_drv = 1'b0;
        cs_n    = 1'b0;
        step(2);
    endtask

    task automatic release_bus();
        cs_n = 1'b1;
        step(2);
    endtask

    // first rise starts output
    // Phases of four cycles leave room for the device's edge detection
    task automatic read_ext(input int nf, output logic [31:0] w);
        w     = '0;
        w[31] = sdo;
        for (int k = 1; k <= nf; k++) begin
            sck_drv = 1'b1;
            step(4);
            sck_drv = 1'b0;
            step(4);
            if (k < 32) w[31-k] = sdo;
        end
    endtask

    // Device clocks the word; sample on each rise of the shared line
    task automatic read_int(output logic [31:0] w, output int per,
                            output int got);
        int   t;
        int   t1;
        logic prev;
        w    = '0;
        got  = 0;
        t    = 0;
        t1   = 0;
        per  = 0;
        prev = sck_line;
        while (got < 32 && t < 4000) begin
            step(1);
            t++;
            if (sck_line && !prev) begin
                w[31-got] = sdo;
                got++;
                if (got == 1) t1 = t;
                if (got == 2) per = t - t1;
            end
            prev = sck_line;
        end
    endtask
endmodule

`default_nettype wire

/* File: test_adc_conversion_serial_readout.sv */
// Self-checking bench for the converter sequencer and its serial port
`timescale 1ns/1ps
`default_nettype none

module test_adc_conversion_serial_readout;
    logic                  ref_clk;
    logic                  rst;
    logic                  rej_pin;
    logic                  ext_run;
    logic signed [29:0]    conv_value;
    adc_pkg::serial_pins_s pins;
    logic                  conv_busy;
    logic                  ext_clk_active;
    logic                  osc_on;
    wire logic             cs_n;
    wire logic             sck_drv;
    wire logic             sck_en;
    wire logic             sck_line;
    wire logic             sdo_line;
    int                    error_cnt;
    int                    cmp_count;
    int                    seed;
    int                    cyc;
    int                    per;
    int                    nbits;
    logic [31:0]           w;

    // Pull-up on the clock pin; a released data pin shows a wrong level
    assign sck_line = pins.sck_oe ? pins.sck_out : (sck_en ? sck_drv : 1'b1);
    assign sdo_line = pins.sdo_oe ? pins.sdo : ~pins.sdo;

    adc_conversion_serial_readout #(.EXT_WINDOW_CYC(64)) DUT (
        .ref_clk              (ref_clk),
        .rst                  (rst),
        .rejection_select_pin (rej_pin),
        .cs_n                 (cs_n),
        .sck_in               (sck_line),
        .conv_value           (conv_value),
        .pins                 (pins),
        .conv_busy            (conv_busy),
        .ext_clk_active       (ext_clk_active),
        .osc_on               (osc_on)
    );

    spi_host_model host (
        .ref_clk  (ref_clk),
        .sdo      (sdo_line),
        .sck_line (sck_line),
        .cs_n     (cs_n),
        .sck_drv  (sck_drv),
        .sck_en   (sck_en)
    );

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // Fastest external conversion clock keeps each conversion short
    always @(posedge ref_clk) if (ext_run) rej_pin <= #1 ~rej_pin;

    function automatic logic [31:0] exp_word(input logic signed [63:0] v);
        if (v > 64'sh11ff_ffff) return 32'h31ff_ffff;
        if (v < -64'sh200_0000) return 32'h1e00_0000;
        return {2'b00, v >= 0, (v < 0) || (v >= 64'sh1000_0000), v[27:0]};
    endfunction

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wait_idle(output int n);
        n = 0;
        while (conv_busy !== 1'b0 && n < 50000) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (n >= 50000) begin
            error_cnt++;
            report_and_stop();
        end
    endtask

    // Cycles between two successive conversion ticks
    task automatic tick_gap(output int n);
        int k;
        int t0;
        n  = 0;
        t0 = -1;
        for (k = 0; k < 5000 && n == 0; k++) begin
            @(posedge ref_clk);
            #1;
            if (DUT.u_clk_src.conv_tick === 1'b1) begin
                if (t0 < 0) t0 = k;
                else n = k - t0;
            end
        end
        if (n == 0) begin
            error_cnt++;
            report_and_stop();
        end
    endtask

    initial begin
        seed       = 42;
        error_cnt  = 0;
        cmp_count  = 0;
        rst        = 1'b1;
        rej_pin    = 1'b0;
        ext_run    = 1'b0;
        conv_value = 30'(($random(seed) & 32'h0fff_ffff) - 32'h0200_0000);
        repeat (4) @(posedge ref_clk);
        #1;
        cmp_bit(pins.sdo_oe, 1'b0);
        cmp_bit(conv_busy, 1'b1);
        rst     = 1'b0;
        ext_run = 1'b1;
        host.step(20);
        cmp_bit(ext_clk_active, 1'b1);
        cmp_bit(osc_on, 1'b0);
        $display("test reset and clock detect done");

        host.select(1'b1);
        cmp_bit(sdo_line, 1'b1);
        cmp_bit(pins.sck_oe, 1'b0);
        host.release_bus();
        cmp_bit(pins.sdo_oe, 1'b0);
        wait_idle(cyc);
        host.select(1'b1);
        cmp_bit(sdo_line, 1'b0);
        host.step(50);
        cmp_bit(conv_busy, 1'b0);
        $display("test pending flag done");

        host.read_ext(15, w);
        cmp_word(w & 32'hffff_0000, exp_word(conv_value) & 32'hffff_0000);
        conv_value = 30'sh1fff_0000;
        host.release_bus();
        host.step(2);
        cmp_bit(conv_busy, 1'b1);
        $display("test external read and abort done");

        wait_idle(cyc);
        cmp_bit(cyc >= 40950 && cyc <= 40970, 1'b1);
        host.select(1'b0);
        cmp_bit(pins.sck_oe, 1'b1);
        host.read_int(w, per, nbits);
        if (nbits != 32) begin
            error_cnt++;
            report_and_stop();
        end
        cmp_word(w, exp_word(conv_value));
        cmp_word(32'(per), 32'h10);
        host.step(12);
        cmp_bit(conv_busy, 1'b1);
        cmp_bit(sdo_line, 1'b1);
        $display("test internal read done");

        host.release_bus();
        ext_run = 1'b0;
        host.step(74);
        cmp_bit(ext_clk_active, 1'b0);
        cmp_bit(osc_on, 1'b1);
        $display("test clock loss done");

        rej_pin = 1'b0;
        tick_gap(cyc);
        cmp_word(32'(cyc), 32'(adc_pkg::OSC60_CYC));
        rej_pin = 1'b1;
        tick_gap(cyc);
        cmp_word(32'(cyc), 32'(adc_pkg::OSC50_CYC));
        $display("test rejection rate done");
        report_and_stop();
    end
endmodule

`default_nettype wire
